// >>> include/prbrc_consts.vh
// Constants for the memory-read control block of a read-only memory board.
// Assumes one 50 MHz clock and an AXI4-Lite master for configuration.
//
// Functional notes
// - Access time runs from read command to acknowledge
// - Access code 1..14 from weights 1,2,4,8
// - 55 ns plus 100 ns per code step
// - One overlap bit per bank, cleared means overlap
// - Overlap bank stretches access to 1455 ns minimum
// - Overlap holds RAM inhibit 50 ns past acknowledge
// - Non-overlap bank uses the access code time
// - Overlap access lasts 15 board clock cycles
// - Addressed read asserts RAM inhibit unless ROM inhibit is asserted
// - Read command selects two chips, starts counter
// - Terminal count sets acknowledge, gated by qualifier
// - Data buffered, off bus when not addressed
// - Pins: 16 data, 2 control out, 24 in
// - Chips idle unless accessed; exactly two selected
// - Four banks of four rows, paired access
// - 8-bit independent banks; 16/8 even/odd banks
// - 16/8 mode shifts address down one bit
// - Row select bits depend on device size
// - ROM inhibit clears counter, acknowledge and RAM inhibit
// - Counter and acknowledge run on board constant clock
// - Byte swap when byte-high-enable false; code copies the high byte onto both halves only at odd address (16/8) or with low word select off (8-bit)
// - Data inverted onto system bus
`ifndef PRBRC_CONSTS_VH
`define PRBRC_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PRBRC_ADDR_CFG        4'h0
`define PRBRC_ADDR_STATUS     4'h4
`define PRBRC_CFG_CODE_LSB    0
`define PRBRC_CFG_OVL_LSB     4
`define PRBRC_CFG_MODE16_BIT  8
`define PRBRC_CFG_SIZE_LSB    9
`define PRBRC_CFG_CODE_RST    4'h1
`define PRBRC_CFG_OVL_RST     4'hF
`define PRBRC_CFG_MODE16_RST  1'b0
`define PRBRC_CFG_SIZE_RST    2'h0
`define PRBRC_SIZE_1K         2'h0
`define PRBRC_SIZE_2K         2'h1
`define PRBRC_RESP_OKAY       2'h0
`define PRBRC_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PRBRC_CLK_PERIOD_NS   20
`define PRBRC_CODE_MIN        4'h1
`define PRBRC_CODE_MAX        4'hE
`define PRBRC_OVL_CYCLES      4'hF
`define PRBRC_ACC_BASE_NS     55
`define PRBRC_ACC_STEP_NS     100
`define PRBRC_OVL_ACC_NS      1455
`define PRBRC_INH_HOLD_NS     50
`define PRBRC_INH_HOLD_CYC    2'h3

`endif

// >>> logic/prbrc_top.v
// Read-cycle control of a read-only memory expansion board on a parallel bus.
// Assumes bus pins arrive asynchronously and configuration comes over AXI4-Lite.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "prbrc_consts.vh"

module prbrc_top #(
   parameter SYNC_W = 43
) (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // AXI4-Lite write address
   input  wire [3:0]  i_awaddr,
   input  wire        i_awvalid,
   output reg         o_awready,
   // AXI4-Lite write data
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output reg         o_wready,
   // AXI4-Lite write response
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   // AXI4-Lite read address
   input  wire [3:0]  i_araddr,
   input  wire        i_arvalid,
   output reg         o_arready,
   // AXI4-Lite read data
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   // System bus inputs, active low
   input  wire [19:0] i_adr_n,
   input  wire        i_mrdc_n,
   input  wire        i_inh2_n,
   input  wire        i_bhen_n,
   input  wire        i_cclk_n,
   // Board decode inputs
   input  wire        i_board_sel,
   input  wire        i_sel_cd,
   input  wire        i_low_word_select_n,
   // Memory buffer data
   input  wire [15:0] i_mem_data,
   // System bus outputs
   output reg         o_xack_n,
   output reg         o_inh1_n,
   output reg  [15:0] o_dat_n,
   output reg  [15:0] o_dat_oe,
   // Memory array
   output reg  [15:0] o_chip_sel_n,
   output reg  [13:0] o_dev_addr,
   output reg         o_board_read_qualifier_n,
   output reg         o_byte_odd_even_select_n
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function [3:0] clamp_code;
      input [3:0] c;
      begin
         if (c < `PRBRC_CODE_MIN) begin
            clamp_code = `PRBRC_CODE_MIN;
         end else if (c > `PRBRC_CODE_MAX) begin
            clamp_code = `PRBRC_CODE_MAX;
         end else begin
            clamp_code = c;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   wire [SYNC_W-1:0] pins_raw;
   reg  [SYNC_W-1:0] sync1_q;
   reg  [SYNC_W-1:0] sync2_q;

   assign pins_raw = {i_mem_data, i_low_word_select_n, i_sel_cd, i_board_sel,
                      i_cclk_n, i_bhen_n, i_inh2_n, i_mrdc_n, i_adr_n};

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1_q <= {SYNC_W{1'b1}};
         sync2_q <= {SYNC_W{1'b1}};
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire [19:0] adr      = ~sync2_q[19:0];
   wire        mrdc     = ~sync2_q[20];
   wire        inh2     = ~sync2_q[21];
   wire        bhen     = ~sync2_q[22];
   wire        cclk     = ~sync2_q[23];
   wire        brd_sel  = sync2_q[24];
   wire        sel_cd   = sync2_q[25];
   wire        low_word_sel = ~sync2_q[26];
   wire [15:0] mem_data = sync2_q[42:27];

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   reg  [3:0] code_q;
   reg  [3:0] ovl_n_q;
   reg        mode16_q;
   reg  [1:0] size_q;
   reg        aw_got_q;
   reg        w_got_q;
   reg  [3:0] aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0] w_strb_q;

   wire aw_take = i_awvalid & o_awready;
   wire w_take  = i_wvalid & o_wready;
   wire [3:0]  wa  = aw_take ? i_awaddr : aw_addr_q;
   wire [31:0] wd  = w_take ? i_wdata : w_data_q;
   wire [3:0]  ws  = w_take ? i_wstrb : w_strb_q;
   wire wr_go = (aw_got_q | aw_take) & (w_got_q | w_take) & ~o_bvalid;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= `PRBRC_RESP_OKAY;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         code_q    <= `PRBRC_CFG_CODE_RST;
         ovl_n_q   <= `PRBRC_CFG_OVL_RST;
         mode16_q  <= `PRBRC_CFG_MODE16_RST;
         size_q    <= `PRBRC_CFG_SIZE_RST;
      end else begin
         if (o_bvalid & i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
         if (wr_go) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b1;
            if (wa == `PRBRC_ADDR_CFG) begin
               o_bresp <= `PRBRC_RESP_OKAY;
               if (ws[0]) begin
                  code_q  <= wd[`PRBRC_CFG_CODE_LSB +: 4];
                  ovl_n_q <= wd[`PRBRC_CFG_OVL_LSB +: 4];
               end
               if (ws[1]) begin
                  mode16_q <= wd[`PRBRC_CFG_MODE16_BIT];
                  size_q   <= wd[`PRBRC_CFG_SIZE_LSB +: 2];
               end
            end else if (wa == `PRBRC_ADDR_STATUS) begin
               o_bresp <= `PRBRC_RESP_OKAY;
            end else begin
               o_bresp <= `PRBRC_RESP_SLVERR;
            end
         end else begin
            if (aw_take) begin
               aw_got_q  <= 1'b1;
               aw_addr_q <= i_awaddr;
               o_awready <= 1'b0;
            end
            if (w_take) begin
               w_got_q  <= 1'b1;
               w_data_q <= i_wdata;
               w_strb_q <= i_wstrb;
               o_wready <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Address shaping and chip selection
   // ----------------------------------------------------------------
   reg  [13:0] ia;
   reg  [1:0]  row;
   reg         swap;
   wire        qual    = mrdc & brd_sel;
   wire        active  = qual & ~inh2;
   wire        ovl_acc = sel_cd ? ~(ovl_n_q[2] & ovl_n_q[3])
                                : ~(ovl_n_q[0] & ovl_n_q[1]);
   wire [3:0]  target  = ovl_acc ? `PRBRC_OVL_CYCLES : clamp_code(code_q);

   always @* begin
      if (mode16_q) begin
         ia = adr[14:1];
      end else begin
         ia = adr[13:0];
      end
      if (size_q == `PRBRC_SIZE_1K) begin
         row = ia[11:10];
      end else if (size_q == `PRBRC_SIZE_2K) begin
         row = ia[12:11];
      end else begin
         row = ia[13:12];
      end
      swap = ~bhen & (mode16_q ? adr[0] : ~low_word_sel);
   end

   // ----------------------------------------------------------------
   // Access counter and acknowledge
   // ----------------------------------------------------------------
   reg        cclk_q;
   reg  [3:0] cnt_q;
   reg        xack_q;
   reg        ovl_q;
   reg  [1:0] hold_q;
   wire       cclk_rise = cclk & ~cclk_q;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cclk_q <= 1'b0;
         cnt_q  <= 4'h0;
         xack_q <= 1'b0;
         ovl_q  <= 1'b0;
         hold_q <= 2'h0;
      end else begin
         cclk_q <= cclk;
         if (!active) begin
            cnt_q  <= 4'h0;
            xack_q <= 1'b0;
            if (inh2) begin
               hold_q <= 2'h0;
            end else if (hold_q != 2'h0) begin
               hold_q <= hold_q - 2'h1;
            end
         end else begin
            ovl_q <= ovl_acc;
            if (cclk_rise && !xack_q) begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q + 4'h1 >= target) begin
                  xack_q <= 1'b1;
                  if (ovl_acc) begin
                     hold_q <= `PRBRC_INH_HOLD_CYC;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus and array outputs
   // ----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_xack_n                 <= 1'b1;
         o_inh1_n                 <= 1'b1;
         o_dat_n                  <= 16'hFFFF;
         o_dat_oe                 <= 16'h0000;
         o_chip_sel_n             <= 16'hFFFF;
         o_dev_addr               <= 14'h0000;
         o_board_read_qualifier_n <= 1'b1;
         o_byte_odd_even_select_n <= 1'b1;
      end else begin
         o_board_read_qualifier_n <= ~qual;
         o_xack_n <= ~(xack_q & qual);
         o_inh1_n <= ~(~inh2 & (active | (ovl_q & hold_q != 2'h0)));
         o_dev_addr <= ia;
         o_byte_odd_even_select_n <= ~adr[0];
         o_chip_sel_n <= 16'hFFFF;
         if (active) begin
            o_chip_sel_n[{sel_cd, 1'b0, row}] <= 1'b0;
            o_chip_sel_n[{sel_cd, 1'b1, row}] <= 1'b0;
         end
         if (active) begin
            o_dat_oe <= 16'hFFFF;
            if (swap) begin
               o_dat_n <= ~{mem_data[15:8], mem_data[15:8]};
            end else begin
               o_dat_n <= ~mem_data;
            end
         end else begin
            o_dat_oe <= 16'h0000;
            o_dat_n  <= 16'hFFFF;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= `PRBRC_RESP_OKAY;
      end else begin
         if (o_rvalid & i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
         end
         if (i_arvalid & o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            if (i_araddr == `PRBRC_ADDR_CFG) begin
               o_rresp <= `PRBRC_RESP_OKAY;
               o_rdata <= {21'h000000, size_q, mode16_q, ovl_n_q, code_q};
            end else if (i_araddr == `PRBRC_ADDR_STATUS) begin
               o_rresp <= `PRBRC_RESP_OKAY;
               o_rdata <= {24'h000000, cnt_q, 1'b0, ovl_q, xack_q, active};
            end else begin
               o_rresp <= `PRBRC_RESP_SLVERR;
               o_rdata <= 32'h0000_0000;
            end
         end
      end
   end

endmodule // prbrc_top

`default_nettype wire

// >>> test/prbrc_chk.sv
// Concurrent checks on the bus side of the memory read control block.
// Assumes binding to prbrc_top; one clock, asynchronous reset high.
`timescale 1ns/1ps
`default_nettype none
module prbrc_chk (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst,
   // Watched bus side
   input wire logic        i_mrdc_n,
   input wire logic        i_inh2_n,
   input wire logic [15:0] i_mem_data,
   input wire logic        o_xack_n,
   input wire logic        o_inh1_n,
   input wire logic [15:0] o_dat_n,
   input wire logic [15:0] o_dat_oe,
   input wire logic [15:0] o_chip_sel_n,
   input wire logic        o_board_read_qualifier_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   xack_qual_a: assert property (!o_xack_n |-> !o_board_read_qualifier_n)
      else $error("ack without read qualifier");
   xack_hold_a: assert property ($fell(o_xack_n) |-> !o_xack_n [*3])
      else $error("ack dropped too early");
   ack_release_a: assert property ($rose(i_mrdc_n) |-> ##[1:5] o_xack_n)
      else $error("ack held after command release");
   two_chips_a: assert property (($countones(o_chip_sel_n) == 16) ||
      ($countones(o_chip_sel_n) == 14)) else $error("chip select count wrong");
   sel_inhibit_a: assert property (o_chip_sel_n != 16'hFFFF |->
      !o_inh1_n && !o_board_read_qualifier_n) else $error("select without inhibit");
   oe_inhibit_a: assert property (o_dat_oe != 16'h0000 |-> !o_inh1_n)
      else $error("data driven outside access");
   rom_inhibit_a: assert property (!i_inh2_n [*4] |-> o_xack_n && o_inh1_n &&
      o_dat_oe == 16'h0000) else $error("board active during rom inhibit");
   idle_quiet_a: assert property (i_mrdc_n [*6] |-> o_xack_n &&
      o_board_read_qualifier_n && o_chip_sel_n == 16'hFFFF) else $error("idle not quiet");
   ovl_tail_a: assert property ($rose(o_xack_n) && !o_inh1_n |->
      !o_inh1_n [*2] ##[1:4] o_inh1_n) else $error("overlap inhibit tail wrong");
   data_inv_a: assert property (o_dat_oe == 16'hFFFF |->
      o_dat_n[15:8] == ~$past(i_mem_data[15:8], 3)) else $error("high byte not inverted");
   // ----------------------------------------------------------------
   // Covers
   // ----------------------------------------------------------------
   ack_c: cover property ($fell(o_xack_n));
   ovl_c: cover property ($rose(o_xack_n) && !o_inh1_n);
   inh_c: cover property (!i_inh2_n && !i_mrdc_n);
endmodule // prbrc_chk
bind prbrc_top prbrc_chk prbrc_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_mrdc_n(i_mrdc_n),
   .i_inh2_n(i_inh2_n), .i_mem_data(i_mem_data), .o_xack_n(o_xack_n), .o_inh1_n(o_inh1_n),
   .o_dat_n(o_dat_n), .o_dat_oe(o_dat_oe), .o_chip_sel_n(o_chip_sel_n),
   .o_board_read_qualifier_n(o_board_read_qualifier_n));
`default_nettype wire

// >>> test/prbrc_master.sv
// Bus master board model issuing memory reads and making the constant clock.
// Assumes the bench calls rd from its own process, one read at a time.
`timescale 1ns/1ps
`default_nettype none
module prbrc_master (
   // Clock and answer
   input wire logic        i_clk,
   input wire logic        i_xack_n,
   input wire logic [15:0] i_dat_n,
   // Bus drive
   output logic     [19:0] o_adr_n,
   output logic            o_mrdc_n,
   output logic            o_inh2_n,
   output logic            o_bhen_n,
   output logic            o_cclk_n
);
   int ecnt;
   initial begin
      o_adr_n = 20'hFFFFF;
      o_mrdc_n = 1'b1;
      o_inh2_n = 1'b1;
      o_bhen_n = 1'b1;
      o_cclk_n = 1'b1;
      ecnt = 0;
   end
   // ----------------------------------------------------------------
   // Constant clock near 9.6 MHz
   // ----------------------------------------------------------------
   always #52 o_cclk_n = ~o_cclk_n;
   always @(negedge o_cclk_n) ecnt++;
   // ----------------------------------------------------------------
   // Read cycle
   // ----------------------------------------------------------------
   task automatic rd(input logic [19:0] a, input logic bh, input logic inh,
                     output int e, output logic [15:0] d, output logic ok);
      int n;
      int e0;
      o_adr_n <= ~a;
      o_bhen_n <= ~bh;
      o_inh2_n <= ~inh;
      repeat (3) @(posedge i_clk);
      @(negedge o_cclk_n);
      @(posedge i_clk);
      o_mrdc_n <= 1'b0;
      e0 = ecnt;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_xack_n && n < 120);
      ok = !i_xack_n;
      e = ecnt - e0;
      d = i_dat_n;
      o_mrdc_n <= 1'b1;
      o_adr_n <= 20'hFFFFF;
      o_bhen_n <= 1'b1;
      o_inh2_n <= 1'b1;
      repeat (10) @(posedge i_clk);
   endtask
endmodule // prbrc_master
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the memory read control block.
// Assumes prbrc_top, the master model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "prbrc_consts.vh"
module tb_top;
   logic        clk = 1'b0;
   logic        rst, awvalid, wvalid, bready, arvalid, rready, bsel, selcd, lws_n;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, v;
   logic [15:0] mdat, d;
   logic [1:0]  r;
   logic        ok;
   wire         awready, wready, bvalid, arready, rvalid, xack_n, inh1_n;
   wire         mrdc_n, inh2_n, bhen_n, cclk_n;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [19:0] adr_n;
   wire  [15:0] dat_n, dat_oe, csel_n;
   int          bad_count, num_checks, cyc, e;
   wire  [13:0] dev_addr;
   wire         oes_n;
   logic [13:0] cap_da;
   logic [15:0] cap_cs;
   logic        cap_oes;
   prbrc_top prbrc_top_i (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_adr_n(adr_n),
      .i_mrdc_n(mrdc_n), .i_inh2_n(inh2_n), .i_bhen_n(bhen_n), .i_cclk_n(cclk_n),
      .i_board_sel(bsel), .i_sel_cd(selcd), .i_low_word_select_n(lws_n), .i_mem_data(mdat),
      .o_xack_n(xack_n), .o_inh1_n(inh1_n), .o_dat_n(dat_n), .o_dat_oe(dat_oe),
      .o_chip_sel_n(csel_n), .o_dev_addr(dev_addr), .o_board_read_qualifier_n(),
      .o_byte_odd_even_select_n(oes_n));
   prbrc_master prbrc_master_i (.i_clk(clk), .i_xack_n(xack_n), .i_dat_n(dat_n),
      .o_adr_n(adr_n), .o_mrdc_n(mrdc_n), .o_inh2_n(inh2_n), .o_bhen_n(bhen_n),
      .o_cclk_n(cclk_n));
   always #10 clk = ~clk;
   // Array side as it stands while acknowledge is shown
   always @(posedge clk) begin
      if (!xack_n) begin
         cap_da  <= dev_addr;
         cap_cs  <= csel_n;
         cap_oes <= oes_n;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         end_sim();
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] dw, input logic [1:0] er);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a; wdata <= dw; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (!ta && awready) begin ta = 1'b1; awvalid <= 1'b0; end
         if (!tw && wready) begin tw = 1'b1; wvalid <= 1'b0; end
      end
      while (!bvalid) @(posedge clk);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [3:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cfg(input logic [3:0] c, input logic [3:0] ov, input logic m);
      axi_wr(4'h0, {23'h0, m, ov, c}, `PRBRC_RESP_OKAY);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      axi_rd(4'h0);
      chk("cfg_reset", 32'h000000F1, v);
      axi_rd(4'h8);
      chk("rresp_unmapped", {30'h0, `PRBRC_RESP_SLVERR}, {30'h0, r});
      axi_wr(4'h4, 32'h0, `PRBRC_RESP_OKAY);
      axi_wr(4'hC, 32'h1, `PRBRC_RESP_SLVERR);
      axi_wr(4'h0, 32'h000006A5, `PRBRC_RESP_OKAY);
      axi_rd(4'h0);
      chk("cfg_back", 32'h000006A5, v);
   endtask
   task automatic t_code();
      int c;
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 1 : ((i == 1) ? 6 : 14);
         cfg(c[3:0], 4'hF, 1'b0);
         prbrc_master_i.rd(20'h00010, 1'b0, 1'b0, e, d, ok);
         chk("ack", 32'h1, {31'h0, ok});
         chk("code_edges", 32'h1, {31'h0, (e == c || e == c + 1)});
      end
   endtask
   task automatic t_ovl();
      cfg(4'h1, 4'hE, 1'b0);
      selcd <= 1'b0;
      prbrc_master_i.rd(20'h00020, 1'b0, 1'b0, e, d, ok);
      chk("ovl_edges", 32'h1, {31'h0, (e == 15 || e == 16)});
      selcd <= 1'b1;
      prbrc_master_i.rd(20'h00020, 1'b0, 1'b0, e, d, ok);
      chk("cd_edges", 32'h1, {31'h0, (e == 1 || e == 2)});
      selcd <= 1'b0;
   endtask
   task automatic t_inh();
      cfg(4'h1, 4'hF, 1'b0);
      prbrc_master_i.rd(20'h00030, 1'b0, 1'b1, e, d, ok);
      chk("inh_noack", 32'h0, {31'h0, ok});
      bsel <= 1'b0;
      prbrc_master_i.rd(20'h00030, 1'b0, 1'b0, e, d, ok);
      chk("desel_noack", 32'h0, {31'h0, ok});
      bsel <= 1'b1;
   endtask
   task automatic t_addr();
      axi_wr(`PRBRC_ADDR_CFG, 32'h000000F1, `PRBRC_RESP_OKAY);
      selcd <= 1'b0;
      prbrc_master_i.rd(20'h00C05, 1'b0, 1'b0, e, d, ok);
      chk("dev_addr_8", 32'h00000C05, {18'h0, cap_da});
      chk("chip_sel_1k", 32'h0000FF77, {16'h0, cap_cs});
      chk("odd_even_8", 32'h0, {31'h0, cap_oes});
      axi_wr(`PRBRC_ADDR_CFG, 32'h000003F1, `PRBRC_RESP_OKAY);
      selcd <= 1'b1;
      prbrc_master_i.rd(20'h02802, 1'b0, 1'b0, e, d, ok);
      chk("dev_addr_16", 32'h00001401, {18'h0, cap_da});
      chk("chip_sel_2k", 32'h0000BBFF, {16'h0, cap_cs});
      chk("odd_even_16", 32'h1, {31'h0, cap_oes});
      axi_wr(`PRBRC_ADDR_CFG, 32'h000004F1, `PRBRC_RESP_OKAY);
      selcd <= 1'b0;
      prbrc_master_i.rd(20'h0A3FF, 1'b0, 1'b0, e, d, ok);
      chk("dev_addr_4k", 32'h000023FF, {18'h0, cap_da});
      chk("chip_sel_4k", 32'h0000FFBB, {16'h0, cap_cs});
   endtask
   task automatic t_data();
      logic [15:0] x;
      mdat <= 16'h5AC3;
      for (int i = 0; i < 5; i++) begin
         cfg(4'h1, 4'hF, i < 3);
         lws_n <= (i == 3);
         x = (i == 0 || i == 3) ? ~16'h5A5A : ~16'h5AC3;
         prbrc_master_i.rd({19'h00040, i != 2}, i == 1, 1'b0, e, d, ok);
         chk("dat_n", {16'h0, x}, {16'h0, d});
      end
   endtask
   initial begin
      rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; bsel = 1'b1; selcd = 1'b0; lws_n = 1'b0; awaddr = 4'h0;
      araddr = 4'h0; wdata = 32'h0; mdat = 16'h1234;
      bad_count = 0; num_checks = 0; cyc = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_code();
      t_ovl();
      t_inh();
      t_addr();
      t_data();
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
